// file: hdl/sdmc_pkg.sv
// Package: shared constants for the mode-register configuration link
`default_nettype none
package sdmc_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned MR_W = 18;
    localparam logic [3:0] SEL_MR1 = 4'h1;
    localparam logic [3:0] SEL_MR2 = 4'h2;
    // MR1 fields
    localparam int unsigned MR1_DLL_BIT = 0;
    localparam int unsigned MR1_AL_LO = 3;
    localparam int unsigned MR1_WLEV_BIT = 7;
    localparam int unsigned MR1_RTN_LO = 8;
    localparam int unsigned MR1_TERMINATION_STROBE_BIT = 11;
    localparam int unsigned MR1_QOFF_BIT = 12;
    // MR2 fields
    localparam int unsigned MR2_CWL_LO = 3;
    localparam int unsigned MR2_SRT_LO = 6;
    localparam int unsigned MR2_RTW_LO = 9;
    localparam int unsigned MR2_CRC_BIT = 12;
    localparam logic [17:0] MR2_RSVD_MASK = 18'h22107;
    localparam logic [17:0] MR1_RESET = 18'h00001;
    localparam logic [17:0] MR2_RESET = 18'h00000;
    localparam logic [2:0] RTT_OFF = 3'h0;
    localparam logic [2:0] RTT_HIZ = 3'h3;
    localparam logic [2:0] RTT_W80 = 3'h4;
    // Lock interval in clock cycles
    localparam int unsigned LOCK_CYC = 768;
    localparam logic [9:0] LOCK_CYC_W = 10'h300;
    typedef enum logic [1:0] {SDMC_TERM_OFF, SDMC_TERM_NOM, SDMC_TERM_WR, SDMC_TERM_PARK} sdmc_term_t;
endpackage
`default_nettype wire

// file: hdl/sdmc_if.sv
// Interface: command/address pins between controller and device
`default_nettype none
interface sdmc_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic termination_control_pin;
    logic [3:0] bank;
    logic [17:0] addr;
    modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, termination_control_pin, bank, addr);
    modport dev (input cs_n, ras_n, cas_n, we_n, cke, termination_control_pin, bank, addr);
endinterface
`default_nettype wire

// file: hdl/sdmc_dev.sv
// Device end: mode registers and the settings derived from them
// Function
// - MR1 bit 0 enables delay-locked loop
// - Loop off in self refresh, back on
// - Controller waits lock interval before reads
// - Clock gate held high during lock
// - Writes need loop only with write termination
// - Loop off: no direct termination used
// - Loop off: write termination field zero
// - Write termination on writes; park when pin low
// - Commands held for additive latency; no command delay here, only additive_latency_o is decoded
// - Additive latency decode, 11 reserved
// - Output-off bit disconnects all outputs
// - Termination strobe only on x8
// - Strobe disables mask and inversions
// - Mode write decode and register select
// - Reserved MR2 bits programmed zero
// - MR2 bit 12 enables write CRC
// - Write termination field decode
// - Self-refresh temperature range decode
// - Write latency decode, one-cycle preamble
// - Two-cycle preamble: low codes invalid
// - Write latency = additive + parity + CAS
// - Write leveling offers only nominal termination
`default_nettype none
module sdmc_dev
    import sdmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    sdmc_if.dev bus,
    input wire logic self_refresh_i,
    input wire logic write_cmd_i,
    input wire logic [4:0] column_latency_i,
    input wire logic [3:0] parity_latency_i,
    input wire logic two_cycle_preamble_i,
    input wire logic gear_down_i,
    input wire logic mask_req_i,
    input wire logic wr_inv_req_i,
    input wire logic rd_inv_req_i,
    output logic [17:0] mr1_o,
    output logic [17:0] mr2_o,
    output logic dll_on_o,
    output logic outputs_off_o,
    output logic [4:0] additive_latency_o,
    output logic al_reserved_o,
    output logic [5:0] total_read_latency_o,
    output logic [4:0] cas_write_latency_o,
    output logic cwl_invalid_o,
    output logic [6:0] total_write_latency_o,
    output logic crc_en_o,
    output logic [1:0] self_refresh_temp_range_o,
    output logic auto_range_switching_o,
    output logic [2:0] write_termination_o,
    output logic wr_term_reserved_o,
    output logic [1:0] term_sel_o,
    output logic write_needs_dll_o,
    output logic byte_mask_en_o,
    output logic wr_inv_en_o,
    output logic rd_inv_en_o
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] cwl_decode(input logic [2:0] code);
        unique case (code)
            3'h0: cwl_decode = 5'h09;
            3'h1: cwl_decode = 5'h0a;
            3'h2: cwl_decode = 5'h0b;
            3'h3: cwl_decode = 5'h0c;
            3'h4: cwl_decode = 5'h0e;
            3'h5: cwl_decode = 5'h10;
            3'h6: cwl_decode = 5'h12;
            default: cwl_decode = 5'h14;
        endcase
    endfunction

    // Bit 21 rides on the top bank pin and is reserved, so only 20:18 select
    function automatic logic sel_hit(input logic [3:0] bank, input logic [3:0] code);
        sel_hit = (bank[2:0] == code[2:0]);
    endfunction

    // The reserved code reads as zero so the latency sums stay defined
    function automatic logic [4:0] al_decode(input logic [1:0] code, input logic [4:0] cl);
        unique case (code)
            2'h1: al_decode = cl - 5'h01;
            2'h2: al_decode = cl - 5'h02;
            default: al_decode = 5'h00;
        endcase
    endfunction

    // Priority: output-off, leveling, write, park, then nominal
    function automatic sdmc_term_t term_pick(input logic qoff, input logic lev, input logic wr,
        input logic termination_control_pin, input logic nom_on);
        if (qoff)
        begin
            term_pick = SDMC_TERM_OFF;
        end
        else if (lev)
        begin
            term_pick = (termination_control_pin && nom_on) ? SDMC_TERM_NOM : SDMC_TERM_OFF;
        end
        else if (wr)
        begin
            term_pick = SDMC_TERM_WR;
        end
        else if (!termination_control_pin)
        begin
            term_pick = SDMC_TERM_PARK;
        end
        else
        begin
            term_pick = nom_on ? SDMC_TERM_NOM : SDMC_TERM_OFF;
        end
    endfunction

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    logic [17:0] mr1_r;
    logic [17:0] mr1_nxt;
    logic [17:0] mr2_r;
    logic [17:0] mr2_nxt;
    logic mode_wr;

    always_comb
    begin
        mode_wr = !bus.cs_n && !bus.ras_n && !bus.cas_n && !bus.we_n;
        mr1_nxt = mr1_r;
        mr2_nxt = mr2_r;
        // Writes to any other register pass by untouched
        if (mode_wr && sel_hit(bus.bank, SEL_MR1))
        begin
            mr1_nxt = bus.addr;
        end
        if (mode_wr && sel_hit(bus.bank, SEL_MR2))
        begin
            // Reserved bits forced clear so a careless write cannot set them
            mr2_nxt = bus.addr & ~MR2_RSVD_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mr1_r <= MR1_RESET;
            mr2_r <= MR2_RESET;
        end
        else
        begin
            mr1_r <= mr1_nxt;
            mr2_r <= mr2_nxt;
        end
    end

    // ------------------------------------------------------------
    // Derived settings
    // ------------------------------------------------------------
    logic [1:0] al_code;
    logic [2:0] cwl_code;
    logic [2:0] nominal_termination;
    logic termination_strobe;
    logic wlev;

    always_comb
    begin
        al_code = mr1_r[MR1_AL_LO +: 2];
        cwl_code = mr2_r[MR2_CWL_LO +: 3];
        nominal_termination = mr1_r[MR1_RTN_LO +: 3];
        termination_strobe = mr1_r[MR1_TERMINATION_STROBE_BIT];
        wlev = mr1_r[MR1_WLEV_BIT];
        mr1_o = mr1_r;
        mr2_o = mr2_r;
        dll_on_o = mr1_r[MR1_DLL_BIT] && !self_refresh_i;
        outputs_off_o = mr1_r[MR1_QOFF_BIT];
        al_reserved_o = (al_code == 2'h3);
        additive_latency_o = al_decode(al_code, column_latency_i);
        // The read sum carries one extra bit and the write sum two, so the largest settings cannot wrap
        total_read_latency_o = {1'b0, additive_latency_o} + {1'b0, column_latency_i};
        cas_write_latency_o = cwl_decode(cwl_code);
        // 9 and 11 are illegal in gear-down; low codes illegal with long preamble
        cwl_invalid_o = (two_cycle_preamble_i && !cwl_code[2])
            || (gear_down_i && (cwl_code == 3'h0 || cwl_code == 3'h2));
        total_write_latency_o = {2'h0, additive_latency_o} + {3'h0, parity_latency_i}
            + {2'h0, cas_write_latency_o};
        crc_en_o = mr2_r[MR2_CRC_BIT];
        self_refresh_temp_range_o = mr2_r[MR2_SRT_LO +: 2];
        auto_range_switching_o = (mr2_r[MR2_SRT_LO +: 2] == 2'h3);
        write_termination_o = mr2_r[MR2_RTW_LO +: 3];
        wr_term_reserved_o = (write_termination_o > RTT_W80);
        write_needs_dll_o = (write_termination_o != RTT_OFF) && !wr_term_reserved_o;
    end

    // ------------------------------------------------------------
    // Termination and pin sharing
    // ------------------------------------------------------------
    always_comb
    begin
        term_sel_o = term_pick(outputs_off_o, wlev, write_cmd_i && write_needs_dll_o, bus.termination_control_pin,
            nominal_termination != RTT_OFF);
        // The shared pin carries the strobe, so mask and both inversions give way
        byte_mask_en_o = !termination_strobe && mask_req_i;
        wr_inv_en_o = !termination_strobe && !mask_req_i && wr_inv_req_i;
        rd_inv_en_o = !termination_strobe && rd_inv_req_i;
    end
endmodule // sdmc_dev
`default_nettype wire

// file: hdl/sdmc_ctrl.sv
// Controller end: issues mode writes and respects lock and termination limits
`default_nettype none
module sdmc_ctrl
    import sdmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    sdmc_if.ctrl bus,
    input wire logic wr_req_i,
    input wire logic wr_sel_mr2_i,
    input wire logic [17:0] wr_data_i,
    input wire logic dll_reset_i,
    input wire logic x8_part_i,
    input wire logic odt_req_i,
    output logic wr_ready_o,
    output logic lock_wait_o,
    output logic read_allowed_o
);
    // ------------------------------------------------------------
    // Command issue and lock tracking
    // ------------------------------------------------------------
    logic mode_wr_r;
    logic mode_wr_nxt;
    logic [3:0] bank_r;
    logic [3:0] bank_nxt;
    logic [17:0] addr_r;
    logic [17:0] addr_nxt;
    logic dll_on_r;
    logic dll_on_nxt;
    logic [9:0] lock_cnt_r;
    logic [9:0] lock_cnt_nxt;
    logic [17:0] d;

    always_comb
    begin
        d = wr_data_i;
        mode_wr_nxt = 1'b0;
        bank_nxt = bank_r;
        addr_nxt = addr_r;
        dll_on_nxt = dll_on_r;
        lock_cnt_nxt = (lock_cnt_r != 10'h000) ? lock_cnt_r - 10'h001 : lock_cnt_r;
        if (dll_reset_i && dll_on_r)
        begin
            lock_cnt_nxt = LOCK_CYC_W;
        end
        if (wr_req_i)
        begin
            if (wr_sel_mr2_i)
            begin
                d = d & ~MR2_RSVD_MASK;
                if (!dll_on_r)
                begin
                    d[MR2_RTW_LO +: 3] = RTT_OFF;
                end
            end
            else
            begin
                if (!x8_part_i)
                begin
                    d[MR1_TERMINATION_STROBE_BIT] = 1'b0;
                end
                if (!d[MR1_DLL_BIT])
                begin
                    d[MR1_RTN_LO +: 3] = RTT_OFF;
                end
                dll_on_nxt = d[MR1_DLL_BIT];
            end
            mode_wr_nxt = 1'b1;
            bank_nxt = wr_sel_mr2_i ? SEL_MR2 : SEL_MR1;
            addr_nxt = d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_wr_r <= 1'b0;
            bank_r <= 4'h0;
            addr_r <= 18'h00000;
            dll_on_r <= 1'b1;
            lock_cnt_r <= 10'h000;
        end
        else
        begin
            mode_wr_r <= mode_wr_nxt;
            bank_r <= bank_nxt;
            addr_r <= addr_nxt;
            dll_on_r <= dll_on_nxt;
            lock_cnt_r <= lock_cnt_nxt;
        end
    end

    always_comb
    begin
        bus.cs_n = !mode_wr_r;
        bus.ras_n = !mode_wr_r;
        bus.cas_n = !mode_wr_r;
        bus.we_n = !mode_wr_r;
        bus.bank = bank_r;
        bus.addr = addr_r;
        bus.cke = 1'b1;
        lock_wait_o = (lock_cnt_r != 10'h000);
        // Synchronous termination waits out the lock just as reads do
        bus.termination_control_pin = odt_req_i && dll_on_r && !lock_wait_o;
        read_allowed_o = dll_on_r && !lock_wait_o;
        wr_ready_o = 1'b1;
    end
endmodule // sdmc_ctrl
`default_nettype wire

// file: tb/sdmc_asserts.sv
// Checker: command-bus properties between controller and device
`default_nettype none
module sdmc_asserts
    import sdmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic termination_control_pin,
    input wire logic [3:0] bank,
    input wire logic [17:0] addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mw, w1, w2;
    // Loop state and nominal field as the device holds them, so rules can follow writes
    logic [3:0] st_r, st_nxt;
    assign mw = !cs_n && !ras_n && !cas_n && !we_n;
    assign w1 = mw && bank[2:0] == 3'h1;
    assign w2 = mw && bank[2:0] == 3'h2;
    always_comb
    begin
        st_nxt = w1 ? {addr[0], addr[10:8]} : st_r;
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_r <= 4'h8;
        else
            st_r <= st_nxt;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----
    // Properties
    // ----
    cmd_whole_a: assert property (!cs_n |-> mw)
        else $error("partial command");
    sel_legal_a: assert property (mw |-> bank[2:0] inside {3'h1, 3'h2})
        else $error("bad register select");
    gate_high_a: assert property (cke)
        else $error("clock gate low");
    rsvd_bits_a: assert property (w2 |-> (addr & MR2_RSVD_MASK) == 18'h0)
        else $error("reserved bits set");
    top_bit_a: assert property (w2 |-> !bank[3])
        else $error("top bit set");
    nom_off_a: assert property (w1 && !addr[0] |-> addr[10:8] == 3'h0)
        else $error("nominal on with loop off");
    dyn_off_a: assert property (w2 && !st_r[3] |-> addr[11:9] == 3'h0)
        else $error("write term on with loop off");
    pin_off_a: assert property (!st_r[3] && !w1 |-> !termination_control_pin)
        else $error("termination pin high with loop off");
    cover property (w1 && !addr[0]);
    cover property (w2 && !st_r[3]);
    cover property (w1 && addr[7]);
endmodule // sdmc_asserts
`default_nettype wire

// file: tb/tb.sv
// Testbench: controller and device ends joined on the command bus
`default_nettype none
module tb import sdmc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, wr_req_i = 0, wr_sel_mr2_i = 0, dll_reset_i = 0;
    logic x8_part_i = 0, odt_req_i = 0, self_refresh_i = 0, write_cmd_i = 0;
    logic two_cycle_preamble_i = 0, mask_req_i = 0, gear_down_i = 0, wr_inv_req_i = 0;
    logic rd_inv_req_i = 0, wr_inv_en_o, rd_inv_en_o, write_needs_dll_o;
    logic [17:0] wr_data_i = 18'h0;
    logic [4:0] column_latency_i = 5'h14;
    logic [3:0] parity_latency_i = 4'h4;
    logic lock_wait_o, read_allowed_o, dll_on_o, al_reserved_o, cwl_invalid_o, crc_en_o;
    logic auto_range_switching_o, wr_term_reserved_o, byte_mask_en_o, outputs_off_o;
    logic [17:0] mr1_o, mr2_o;
    logic [4:0] additive_latency_o, cas_write_latency_o;
    logic [5:0] total_read_latency_o;
    logic [6:0] total_write_latency_o;
    logic [1:0] term_sel_o, self_refresh_temp_range_o;
    logic [2:0] write_termination_o;
    logic [4:0] cw [8] = '{5'h9, 5'ha, 5'hb, 5'hc, 5'he, 5'h10, 5'h12, 5'h14};
    int compares = 0, miscompares = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    sdmc_if sdmc_if_inst ();
    sdmc_ctrl sdmc_ctrl_inst (.clk_i, .rst_i, .bus(sdmc_if_inst), .wr_req_i, .wr_sel_mr2_i,
        .wr_data_i, .dll_reset_i, .x8_part_i, .odt_req_i, .wr_ready_o(), .lock_wait_o,
        .read_allowed_o);
    sdmc_dev sdmc_dev_inst (.clk_i, .rst_i, .bus(sdmc_if_inst), .self_refresh_i,
        .write_cmd_i, .column_latency_i, .parity_latency_i, .two_cycle_preamble_i,
        .gear_down_i, .mask_req_i, .wr_inv_req_i, .rd_inv_req_i, .mr1_o,
        .mr2_o, .dll_on_o, .outputs_off_o, .additive_latency_o, .al_reserved_o,
        .total_read_latency_o, .cas_write_latency_o, .cwl_invalid_o,
        .total_write_latency_o, .crc_en_o, .self_refresh_temp_range_o,
        .auto_range_switching_o, .write_termination_o, .wr_term_reserved_o, .term_sel_o,
        .write_needs_dll_o, .byte_mask_en_o, .wr_inv_en_o, .rd_inv_en_o);
    sdmc_asserts sdmc_asserts_inst (.clk_i, .rst_i, .cs_n(sdmc_if_inst.cs_n),
        .ras_n(sdmc_if_inst.ras_n), .cas_n(sdmc_if_inst.cas_n), .we_n(sdmc_if_inst.we_n),
        .cke(sdmc_if_inst.cke), .termination_control_pin(sdmc_if_inst.termination_control_pin), .bank(sdmc_if_inst.bank),
        .addr(sdmc_if_inst.addr));
    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chb(input logic g, input logic e);
        chk(18'(g), 18'(e));
    endtask
    // Inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask
    task automatic mw(input logic s, input logic [17:0] d);
        wr_sel_mr2_i = s;
        wr_data_i = d;
        wr_req_i = 1;
        step;
        wr_req_i = 0;
        step;
    endtask
    task automatic t_al;
        logic [17:0] e;
        for (int i = 0; i < 4; i++)
        begin
            e = (i == 1) ? 18'h13 : (i == 2) ? 18'h12 : 18'h0;
            mw(0, 18'h1 | 18'(i << 3));
            chk(18'(additive_latency_o), e);
            chk(18'(total_read_latency_o), e + 18'h14);
            chb(al_reserved_o, i == 3);
        end
    endtask
    task automatic t_mr2;
        logic [17:0] d;
        // Pass 2 runs gear-down with the short preamble
        for (int p = 0; p < 3; p++)
        begin
            two_cycle_preamble_i = p[0];
            gear_down_i = p[1];
            for (int i = 0; i < 8; i++)
            begin
                d = 18'((i << 3) | (i << 9) | ((i & 3) << 6) | ((i & 1) << 12));
                mw(1, d);
                chk(mr2_o, d);
                chb(cwl_invalid_o, (p == 1 && i < 4) || (p == 2 && i inside {0, 2}));
                chk(18'(cas_write_latency_o), 18'(cw[i]));
                chk(18'(write_termination_o), 18'(i));
                chk(18'(self_refresh_temp_range_o), 18'(i & 3));
                chb(write_needs_dll_o, i > 0 && i < 5);
                if (p != 1 || i > 3)
                    chk(18'(total_write_latency_o), 18'(cw[i]) + 18'h4);
                chb(wr_term_reserved_o, i > 4);
                chb(crc_en_o, i[0]);
                chb(auto_range_switching_o, i[1:0] == 2'h3);
            end
        end
        gear_down_i = 0;
        mw(1, 18'h3ffff);
        chk(mr2_o, 18'h3ffff & ~MR2_RSVD_MASK);
    endtask
    task automatic t_dll;
        mw(0, 18'h00f00);
        chk(mr1_o, 18'h0);
        chb(dll_on_o, 1'b0);
        mw(1, 18'h00200);
        chk(mr2_o, 18'h0);
        odt_req_i = 1;
        step;
        chb(sdmc_if_inst.termination_control_pin, 1'b0);
        odt_req_i = 0;
        mw(0, 18'h00001);
        self_refresh_i = 1;
        step;
        chb(dll_on_o, 1'b0);
        self_refresh_i = 0;
        step;
        chb(dll_on_o, 1'b1);
    endtask
    task automatic t_term;
        x8_part_i = 1;
        mask_req_i = 1;
        wr_inv_req_i = 1;
        rd_inv_req_i = 1;
        mw(0, 18'h00801);
        chk(mr1_o, 18'h00801);
        chb(byte_mask_en_o, 1'b0);
        chb(wr_inv_en_o, 1'b0);
        chb(rd_inv_en_o, 1'b0);
        mw(1, 18'h00200);
        chk(18'(term_sel_o), 18'h3);
        odt_req_i = 1;
        write_cmd_i = 1;
        step;
        chk(18'(term_sel_o), 18'h2);
        mw(0, 18'h00181);
        chk(18'(term_sel_o), 18'h1);
        mw(0, 18'h01001);
        chb(outputs_off_o, 1'b1);
        chk(18'(term_sel_o), 18'h0);
        mw(0, 18'h00001);
        chb(byte_mask_en_o, 1'b1);
        chb(wr_inv_en_o, 1'b0);
        chb(rd_inv_en_o, 1'b1);
        mask_req_i = 0;
        step;
        chb(wr_inv_en_o, 1'b1);
    endtask
    task automatic t_lock;
        dll_reset_i = 1;
        step;
        dll_reset_i = 0;
        chb(lock_wait_o, 1'b1);
        chb(sdmc_if_inst.termination_control_pin, 1'b0);
        repeat (LOCK_CYC - 1) step;
        chb(read_allowed_o, 1'b0);
        step;
        chb(read_allowed_o, 1'b1);
        chb(sdmc_if_inst.termination_control_pin, 1'b1);
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        #1 rst_i = 0;
        chk(mr1_o, MR1_RESET);
        t_al;
        t_mr2;
        t_dll;
        t_term;
        t_lock;
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
